// ==== pin_mux_defines.vh ====
// register offsets, field positions and reset values for the boot status and pin mux block
// assumes a byte-addressed register port with 8-bit addresses, one 32-bit register every 4 bytes
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH
`define ADDR_STATUS 8'h00
`define ADDR_GPIO_EN 8'h04
`define ADDR_GPIO_DIR 8'h08
`define ADDR_GPIO_OUT 8'h0C
`define ADDR_GPIO_IN 8'h10
`define ADDR_MAC_SEL 8'h14
`define BIT_RESERVED7 7
`define BIT_PCI_SEL 8
`define BIT_MAC_SEL 11
`define RESERVED7_VALUE 1'b0
`define GPIO_IDX_QUARTER 0
`define GPIO_IDX_SIXTH 1
`define GPIO_IDX_VCXO 2
`define GPIO_COUNT 3
`define GPIO_RESET 3'h0
`define STRAP_RESET 8'h10
`define MUX_NOT_GPIO 1'b0
`define DIR_OUTPUT 1'b1
`define OE_DRIVE 1'b0
`define GPIO_FREE 1'b1
`define CAPTURE_IDLE 1'b0
`define CAPTURE_DONE 1'b1
`define MULT_RESET 2'b00
`define ENDIAN_RESET 1'b1
`define BOOT_RESET 2'b00
`define EXTCLK_RESET 2'b00
`define PCI_RESET 1'b0
`define MAC_RESET 1'b0
`define BIT_ENDIAN 4
`define FLD_UPPER_HI 31
`define FLD_UPPER_LO 12
`define FLD_MID_HI 10
`define FLD_MID_LO 9
`define FLD_MULT_HI 6
`define FLD_MULT_LO 5
`define FLD_BOOT_HI 3
`define FLD_BOOT_LO 2
`define FLD_EXTCLK_HI 1
`define FLD_EXTCLK_LO 0
`define UPPER_ZERO 20'h00000
`define MID_ZERO 2'b00
`define PAD29_ZERO 29'h0000000
`define PAD31_ZERO 31'h00000000
`define WORD_ZERO 32'h00000000
`endif

// ==== boot_config_status_and_pin_mux.v ====
// boot configuration status word and shared-pin multiplexer
// holds the strap latch, the gpio takeover registers and the register read path
// assumes straps are stable around reset release and inputs are synchronous to clk_sys
// assumes software sets the mux registers once after reset and leaves them alone
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "pin_mux_defines.vh"

module boot_config_status_and_pin_mux (
  input wire clk_sys,
  input wire resetn,
  input wire clk_en,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire cpu_multiplier_sel_hi,
  input wire cpu_multiplier_sel_lo,
  input wire byte_order_strap,
  input wire boot_source_hi,
  input wire boot_source_lo,
  input wire extmem_clock_sel_hi,
  input wire extmem_clock_sel_lo,
  input wire pci_config_select,
  input wire cpu_quarter_clock,
  input wire cpu_sixth_clock,
  input wire vcxo_control,
  input wire [2:0] pad_in,
  output wire [2:0] pad_out,
  output wire [2:0] pad_oe_n,
  output wire [2:0] gpio_pin_in,
  output wire pci_active,
  output wire host_mac_gpio_active,
  output wire ethernet_mac_active,
  output wire [1:0] extmem_clock_sel,
  output wire byte_order_flag
);

  // latched strap fields, one register per field
  reg [1:0] strap_mult;
  reg strap_endian;
  reg [1:0] strap_boot;
  reg [1:0] strap_extclk;
  reg strap_pci;
  reg captured;

  // software-written mux registers
  reg [2:0] gpio_pin_enable;
  reg [2:0] gpio_pin_direction;
  reg [2:0] gpio_out;
  reg ethernet_mac_select;

  // next values of every stored field
  wire [1:0] next_strap_mult;
  wire next_strap_endian;
  wire [1:0] next_strap_boot;
  wire [1:0] next_strap_extclk;
  wire next_strap_pci;
  wire next_captured;
  wire [2:0] next_gpio_pin_enable;
  wire [2:0] next_gpio_pin_direction;
  wire [2:0] next_gpio_out;
  wire next_ethernet_mac_select;

  // register port decode and write enables
  wire capture_now;
  wire sel_status;
  wire sel_gpio_en;
  wire sel_gpio_dir;
  wire sel_gpio_out;
  wire sel_gpio_in;
  wire sel_mac;
  wire rd_hit;
  wire wr_gpio_en;
  wire wr_gpio_dir;
  wire wr_gpio_out;
  wire wr_mac;

  // read words, one per register
  wire [31:0] status_word;
  wire [31:0] word_gpio_en;
  wire [31:0] word_gpio_dir;
  wire [31:0] word_gpio_out;
  wire [31:0] word_gpio_in;
  wire [31:0] word_mac;
  reg [31:0] next_rdata;

  // pin mux sources and ownership
  wire [2:0] func_out;
  wire [2:0] gpio_allowed;
  wire [2:0] gpio_take;

  // straps are taken once, on the first enabled edge after reset release
  assign capture_now = ~captured;
  assign next_captured = capture_now ? `CAPTURE_DONE : captured;

  // clock and boot straps: pins while capturing, held afterwards until the next reset
  assign next_strap_mult = capture_now ?
                           {cpu_multiplier_sel_hi, cpu_multiplier_sel_lo} : strap_mult;
  assign next_strap_endian = capture_now ? byte_order_strap : strap_endian;
  assign next_strap_boot = capture_now ? {boot_source_hi, boot_source_lo} : strap_boot;

  // memory clock and pci straps, same capture rule
  assign next_strap_extclk = capture_now ?
                             {extmem_clock_sel_hi, extmem_clock_sel_lo} : strap_extclk;
  assign next_strap_pci = capture_now ? pci_config_select : strap_pci;

  // gpio register next values: new data on a matching write, otherwise held
  assign next_gpio_pin_enable = wr_gpio_en ? wdata[`GPIO_COUNT-1:0] : gpio_pin_enable;
  assign next_gpio_pin_direction = wr_gpio_dir ? wdata[`GPIO_COUNT-1:0] : gpio_pin_direction;
  assign next_gpio_out = wr_gpio_out ? wdata[`GPIO_COUNT-1:0] : gpio_out;

  // mac select next value
  assign next_ethernet_mac_select = wr_mac ? wdata[0] : ethernet_mac_select;

  // capture marker, cleared only by reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      captured <= `CAPTURE_IDLE;
    end else if (clk_en) begin
      captured <= next_captured;
    end
  end

  // cpu multiplier strap, bypass until captured
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_mult <= `MULT_RESET;
    end else if (clk_en) begin
      strap_mult <= next_strap_mult;
    end
  end

  // byte order strap, little-endian until captured
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_endian <= `ENDIAN_RESET;
    end else if (clk_en) begin
      strap_endian <= next_strap_endian;
    end
  end

  // boot source strap, no boot until captured
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_boot <= `BOOT_RESET;
    end else if (clk_en) begin
      strap_boot <= next_strap_boot;
    end
  end

  // memory clock source strap, input pin until captured
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_extclk <= `EXTCLK_RESET;
    end else if (clk_en) begin
      strap_extclk <= next_strap_extclk;
    end
  end

  // pci select strap, disabled until captured
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      strap_pci <= `PCI_RESET;
    end else if (clk_en) begin
      strap_pci <= next_strap_pci;
    end
  end

  // gpio enables, cleared so the default functions own the pins
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_pin_enable <= `GPIO_RESET;
    end else if (clk_en) begin
      gpio_pin_enable <= next_gpio_pin_enable;
    end
  end

  // gpio directions, input after reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_pin_direction <= `GPIO_RESET;
    end else if (clk_en) begin
      gpio_pin_direction <= next_gpio_pin_direction;
    end
  end

  // gpio output levels
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gpio_out <= `GPIO_RESET;
    end else if (clk_en) begin
      gpio_out <= next_gpio_out;
    end
  end

  // mac select, disabled after reset
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ethernet_mac_select <= `MAC_RESET;
    end else if (clk_en) begin
      ethernet_mac_select <= next_ethernet_mac_select;
    end
  end

  // address decode for the register port
  assign sel_status = (addr == `ADDR_STATUS);
  assign sel_gpio_en = (addr == `ADDR_GPIO_EN);
  assign sel_gpio_dir = (addr == `ADDR_GPIO_DIR);
  assign sel_gpio_out = (addr == `ADDR_GPIO_OUT);
  assign sel_gpio_in = (addr == `ADDR_GPIO_IN);
  assign sel_mac = (addr == `ADDR_MAC_SEL);

  // writes reach only the mux registers; status and unmapped addresses are ignored
  assign wr_gpio_en = wr_stb & sel_gpio_en;
  assign wr_gpio_dir = wr_stb & sel_gpio_dir;
  assign wr_gpio_out = wr_stb & sel_gpio_out;
  assign wr_mac = wr_stb & sel_mac;

  // a read of a mapped address returns its word, anything else returns zero
  assign rd_hit = rd_stb & (sel_status | sel_gpio_en | sel_gpio_dir | sel_gpio_out |
                            sel_gpio_in | sel_mac);

  // read word chosen in the strobe cycle, registered into rdata
  always @* begin
    next_rdata = `WORD_ZERO;
    if (rd_hit) begin
      case (addr)
        // latched configuration
        `ADDR_STATUS: begin
          next_rdata = status_word;
        end
        // gpio enables
        `ADDR_GPIO_EN: begin
          next_rdata = word_gpio_en;
        end
        // gpio directions
        `ADDR_GPIO_DIR: begin
          next_rdata = word_gpio_dir;
        end
        // gpio output levels
        `ADDR_GPIO_OUT: begin
          next_rdata = word_gpio_out;
        end
        // raw pad levels
        `ADDR_GPIO_IN: begin
          next_rdata = word_gpio_in;
        end
        // mac select
        `ADDR_MAC_SEL: begin
          next_rdata = word_mac;
        end
        // unmapped
        default: begin
          next_rdata = `WORD_ZERO;
        end
      endcase
    end
  end

  // read data stands for the one cycle after the strobe, zero otherwise
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= `WORD_ZERO;
    end else if (clk_en) begin
      rdata <= next_rdata;
    end
  end

  // status word upper part: reserved zeros around the mac select
  assign status_word[`FLD_UPPER_HI:`FLD_UPPER_LO] = `UPPER_ZERO;
  assign status_word[`BIT_MAC_SEL] = ethernet_mac_select;
  assign status_word[`FLD_MID_HI:`FLD_MID_LO] = `MID_ZERO;
  // pci select and the fixed reserved bit; no write path reaches either
  assign status_word[`BIT_PCI_SEL] = strap_pci;
  assign status_word[`BIT_RESERVED7] = `RESERVED7_VALUE;
  // latched clock, byte order, boot and memory clock straps
  assign status_word[`FLD_MULT_HI:`FLD_MULT_LO] = strap_mult;
  assign status_word[`BIT_ENDIAN] = strap_endian;
  assign status_word[`FLD_BOOT_HI:`FLD_BOOT_LO] = strap_boot;
  assign status_word[`FLD_EXTCLK_HI:`FLD_EXTCLK_LO] = strap_extclk;

  // mux register read words, zero above the used bits
  assign word_gpio_en = {`PAD29_ZERO, gpio_pin_enable};
  assign word_gpio_dir = {`PAD29_ZERO, gpio_pin_direction};
  assign word_gpio_out = {`PAD29_ZERO, gpio_out};
  assign word_gpio_in = {`PAD29_ZERO, pad_in};
  assign word_mac = {`PAD31_ZERO, ethernet_mac_select};

  // global pci select from the latched strap: one owner per function group
  assign pci_active = strap_pci;
  assign host_mac_gpio_active = ~strap_pci;
  assign ethernet_mac_active = ethernet_mac_select & ~strap_pci;

  // strap-routed configuration shown to the rest of the device
  assign extmem_clock_sel = strap_extclk;
  assign byte_order_flag = strap_endian;

  // default function source per pin
  assign func_out[`GPIO_IDX_QUARTER] = cpu_quarter_clock;
  assign func_out[`GPIO_IDX_SIXTH] = cpu_sixth_clock;
  assign func_out[`GPIO_IDX_VCXO] = vcxo_control;

  // gpio permission per pin: the vcxo pin only with pci off
  assign gpio_allowed[`GPIO_IDX_QUARTER] = `GPIO_FREE;
  assign gpio_allowed[`GPIO_IDX_SIXTH] = `GPIO_FREE;
  assign gpio_allowed[`GPIO_IDX_VCXO] = ~strap_pci;

  // per-pin mux: default function drives, gpio takes over when enabled and allowed
  genvar i;
  generate
    for (i = 0; i < `GPIO_COUNT; i = i + 1) begin : g_pin
      wire pin_dir_out;
      wire pin_gpio_oe_n;
      wire pin_func;
      assign gpio_take[i] = gpio_pin_enable[i] & gpio_allowed[i];
      assign pin_dir_out = (gpio_pin_direction[i] == `DIR_OUTPUT);
      assign pin_gpio_oe_n = ~pin_dir_out;
      assign pin_func = func_out[i];
      assign pad_out[i] = gpio_take[i] ? gpio_out[i] : pin_func;
      assign pad_oe_n[i] = gpio_take[i] ? pin_gpio_oe_n : `OE_DRIVE;
      assign gpio_pin_in[i] = gpio_take[i] ? pad_in[i] : `MUX_NOT_GPIO;
    end
  endgenerate

endmodule // boot_config_status_and_pin_mux

// ==== pin_mux_chk_assertions.sv ====
// assertions on status reads, strap hold and default pin ownership
// assumes bind onto the top module with clk_en held high
`timescale 1ns/1ps
module pin_mux_chk (
  input wire clk_sys, input wire resetn, input wire rd_stb,
  input wire [7:0] addr, input wire [31:0] rdata, input wire pci_active,
  input wire host_mac_gpio_active, input wire ethernet_mac_active,
  input wire [2:0] pad_out, input wire [2:0] pad_oe_n, input wire vcxo_control
);
  // all checks on the system clock, quiet in reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_rsv_zero: assert property (rdata[7] == 1'h0)
    else $error("bit 7 set");
  chk_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 32'h0)
    else $error("stray read data");
  chk_pci_shown: assert property ($past(rd_stb) && $past(addr) == 8'h00 |-> rdata[8] == pci_active)
    else $error("pci bit wrong");
  chk_host_inverse: assert property (host_mac_gpio_active == !pci_active)
    else $error("host select wrong");
  chk_mac_gated: assert property (ethernet_mac_active |-> !pci_active)
    else $error("mac with pci");
  chk_pin_default: assert property (!$past(resetn) |-> pad_oe_n == 3'h0)
    else $error("pins not driven");
  chk_vcxo_kept: assert property (pci_active |-> pad_out[2] == vcxo_control && !pad_oe_n[2])
    else $error("vcxo pin lost");
  chk_strap_hold: assert property ($past(resetn, 2) |-> $stable(pci_active))
    else $error("strap moved");
endmodule // pin_mux_chk
bind boot_config_status_and_pin_mux pin_mux_chk pin_mux_chk_inst (.clk_sys(clk_sys),
  .resetn(resetn), .rd_stb(rd_stb), .addr(addr), .rdata(rdata), .pci_active(pci_active),
  .host_mac_gpio_active(host_mac_gpio_active), .ethernet_mac_active(ethernet_mac_active),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n), .vcxo_control(vcxo_control));

// ==== boot_config_status_and_pin_mux_tb.sv ====
// bench: strap table through status reads, then gpio takeover
// assumes the register map of the shared defines
`timescale 1ns/1ps
`include "pin_mux_defines.vh"
module boot_config_status_and_pin_mux_tb;
  reg clk_sys = 0, resetn = 0, wr_stb = 0, rd_stb = 0;
  reg [7:0] addr = 0, s = 0;
  reg [31:0] wdata = 0;
  reg [2:0] q = 0;
  wire [31:0] rdata;
  wire [2:0] po, oe, gi;
  wire pa, ma, bo;
  wire [1:0] ec;
  integer fails = 0, samples_checked = 0, cyc = 0, i;
  reg [7:0] rows [0:3];
  // block under test, clk_en held high
  boot_config_status_and_pin_mux boot_config_status_and_pin_mux_inst (.clk_sys(clk_sys),
    .resetn(resetn), .clk_en(1'h1), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .cpu_multiplier_sel_hi(s[6]), .cpu_multiplier_sel_lo(s[5]),
    .byte_order_strap(s[4]), .boot_source_hi(s[3]), .boot_source_lo(s[2]),
    .extmem_clock_sel_hi(s[1]), .extmem_clock_sel_lo(s[0]), .pci_config_select(s[7]),
    .cpu_quarter_clock(q[0]), .cpu_sixth_clock(q[1]), .vcxo_control(q[2]), .pad_in(3'h2),
    .pad_out(po), .pad_oe_n(oe), .gpio_pin_in(gi), .pci_active(pa),
    .host_mac_gpio_active(), .ethernet_mac_active(ma), .extmem_clock_sel(ec),
    .byte_order_flag(bo));
  // clock, default pin sources, hang guard
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    q <= q + 3'h1;
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      results;
    end
  end
  task chk(input string n, input [31:0] e, input [31:0] g); begin
    samples_checked = samples_checked + 1;
    if (e !== g) begin
      fails = fails + 1;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  end endtask
  task wr(input [7:0] a, input [31:0] d); begin
    addr <= a; wdata <= d; wr_stb <= 1'h1;
    @(posedge clk_sys) wr_stb <= 1'h0;
    @(posedge clk_sys);
  end endtask
  task rd(input [7:0] a, input [31:0] e, input string n); begin
    addr <= a; rd_stb <= 1'h1;
    @(posedge clk_sys) rd_stb <= 1'h0;
    @(negedge clk_sys) chk(n, e, rdata);
    @(posedge clk_sys);
  end endtask
  task rst(input [7:0] v); begin
    s <= v; resetn <= 1'h0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (2) @(posedge clk_sys);
  end endtask
  task gp(input [31:0] dir, input [31:0] val); begin
    wr(`ADDR_GPIO_EN, 32'h7); wr(`ADDR_GPIO_DIR, dir); wr(`ADDR_GPIO_OUT, val);
  end endtask
  task results; begin
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end endtask
  // strap rows, then gpio takeover with pci on and off
  initial begin
    rows[0] = 8'h10; rows[1] = 8'hA5; rows[2] = 8'h4A; rows[3] = 8'hFF;
    for (i = 0; i < 4; i = i + 1) begin
      rst(rows[i]);
      chk("oe_def", 32'h0, {29'h0, oe});
      chk("endian", {31'h0, rows[i][4]}, {31'h0, bo});
      chk("extclk", {30'h0, rows[i][1:0]}, {30'h0, ec});
      chk("pci", {31'h0, rows[i][7]}, {31'h0, pa});
      @(negedge clk_sys) chk("pad_def", {29'h0, q}, {29'h0, po});
      @(posedge clk_sys);
      rd(8'h00, {23'h0, rows[i][7], 1'h0, rows[i][6:0]}, "status");
      s <= ~rows[i];
      wr(8'h00, 32'hFFFFFFFF);
      wr(`ADDR_MAC_SEL, 32'h1);
      rd(8'h00, {20'h0, 1'h1, 2'h0, rows[i][7], 1'h0, rows[i][6:0]}, "held");
      chk("mac", {31'h0, ~rows[i][7]}, {31'h0, ma});
    end
    gp(32'h5, 32'h0);
    chk("oe_pci", 32'h2, {29'h0, oe});
    chk("out_pci", 32'h0, {31'h0, po[0]});
    rst(8'h10);
    gp(32'h1, 32'h1);
    chk("oe_gp8", 32'h6, {29'h0, oe});
    chk("gpio_in", 32'h2, {29'h0, gi});
    rd(8'hFC, 32'h0, "unmapped");
    results;
  end
endmodule // boot_config_status_and_pin_mux_tb
